/* File: rtl/tsfc_top.v */
// Task state fault checker with its APB register file.
`timescale 1ns/1ps
`default_nettype none
`include "tsfc_defines.vh"
module tsfc_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg fault_pulse,
  output reg [7:0] fault_vector,
  output reg double_fault
);
  // ****************************************************************
  // Register file
  // ****************************************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_PRE = 2'h1;
  localparam ST_POST = 2'h2;
  localparam ST_DONE = 2'h3;

  reg [1:0] state_q;
  reg [31:0] ctrl_q;
  reg [31:0] tsssel_q;
  reg [17:0] tssflg_q;
  reg [15:0] ldtsel_q;
  reg [20:0] sssel_q;
  reg [20:0] cssel_q;
  reg [20:0] dssel_q;
  reg [15:0] errcode_q;
  reg [15:0] taskreg_q;
  reg link_q;
  reg [3:0] loaded_q;
  reg [3:0] checked_q;
  reg fault_q;
  reg ctx_new_q;
  reg ip_new_q;
  reg errv_q;
  reg commit_q;
  reg done_q;
  reg pwdata_coproc_q;

  wire wr_en = psel & penable & pwrite;
  wire rd_ok;
  wire go = wr_en & (paddr == `TSFC_OFS_CTRL) & pwdata[`TSFC_CTRL_GO] &
    (state_q == ST_IDLE);

  assign pready = 1'b1;
  assign rd_ok = (paddr == `TSFC_OFS_CTRL) | (paddr == `TSFC_OFS_TSSSEL) |
    (paddr == `TSFC_OFS_TSSFLG) | (paddr == `TSFC_OFS_LDTSEL) |
    (paddr == `TSFC_OFS_SSSEL) | (paddr == `TSFC_OFS_CSSEL) |
    (paddr == `TSFC_OFS_DSSEL) | (paddr == `TSFC_OFS_STATUS) |
    (paddr == `TSFC_OFS_ERRCODE) | (paddr == `TSFC_OFS_TASKREG);
  assign pslverr = psel & penable & ~rd_ok;

  // Inputs are frozen while a check runs so an operation sees one snapshot.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `TSFC_CTRL_RST;
      tsssel_q <= 32'h0000_0000;
      tssflg_q <= 18'h00000;
      ldtsel_q <= 16'h0000;
      sssel_q <= 21'h000000;
      cssel_q <= 21'h000000;
      dssel_q <= 21'h000000;
    end else if (wr_en && state_q == ST_IDLE) begin
      case (paddr)
        `TSFC_OFS_CTRL: ctrl_q <= {pwdata[31:1], 1'b0};
        `TSFC_OFS_TSSSEL: tsssel_q <= pwdata;
        `TSFC_OFS_TSSFLG: tssflg_q <= pwdata[17:0];
        `TSFC_OFS_LDTSEL: ldtsel_q <= pwdata[15:0];
        `TSFC_OFS_SSSEL: sssel_q <= pwdata[20:0];
        `TSFC_OFS_CSSEL: cssel_q <= pwdata[20:0];
        `TSFC_OFS_DSSEL: dssel_q <= pwdata[20:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  always @* begin
    case (paddr)
      `TSFC_OFS_CTRL: prdata = ctrl_q;
      `TSFC_OFS_TSSSEL: prdata = tsssel_q;
      `TSFC_OFS_TSSFLG: prdata = {14'h0000, tssflg_q};
      `TSFC_OFS_LDTSEL: prdata = {16'h0000, ldtsel_q};
      `TSFC_OFS_SSSEL: prdata = {11'h000, sssel_q};
      `TSFC_OFS_CSSEL: prdata = {11'h000, cssel_q};
      `TSFC_OFS_DSSEL: prdata = {11'h000, dssel_q};
      `TSFC_OFS_STATUS: prdata = {8'h00, checked_q, loaded_q, fault_vector,
        commit_q, errv_q, double_fault, ip_new_q, ctx_new_q, fault_q,
        done_q, (state_q != ST_IDLE)};
      `TSFC_OFS_ERRCODE: prdata = {16'h0000, errcode_q};
      `TSFC_OFS_TASKREG: prdata = {15'h0000, link_q, taskreg_q};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Operation decode
  // ****************************************************************
  wire [2:0] op = ctrl_q[`TSFC_CTRL_OP_HI:`TSFC_CTRL_OP_LO];
  wire lm = ctrl_q[`TSFC_CTRL_LONG];
  wire [1:0] current_privilege_level = ctrl_q[`TSFC_CTRL_CPL_HI:`TSFC_CTRL_CPL_LO];
  wire [15:0] tsel = tsssel_q[15:0];
  wire [15:0] tlim = tsssel_q[31:16];
  wire t_null = (tsel[15:2] == 14'h0000);
  wire t_ti = tsel[2];
  wire is_interrupt_return_instr = (op == `TSFC_OP_INTERRUPT_RETURN_INSTR);
  wire is_jmp = (op == `TSFC_OP_JMP);
  wire is_call = (op == `TSFC_OP_CALL) | (op == `TSFC_OP_EXC);
  wire is_sw = is_interrupt_return_instr | is_jmp | is_call;
  wire is_ltr = (op == `TSFC_OP_LTR);
  wire is_priv = (op == `TSFC_OP_PRIV);
  wire [17:0] f = tssflg_q;

  // ****************************************************************
  // Ordered pre-commit checks
  // ****************************************************************
  wire [23:0] pre_fail;
  wire pre_any;
  assign pre_fail[0] = is_sw & (ctrl_q[`TSFC_CTRL_TSS32] ?
    (tlim < `TSFC_LIM32) : (tlim < `TSFC_LIM16));
  assign pre_fail[1] = is_interrupt_return_instr & t_ti;
  assign pre_fail[2] = is_interrupt_return_instr & f[`TSFC_F_SELBEY];
  assign pre_fail[3] = is_interrupt_return_instr & ~f[`TSFC_F_BUSY];
  assign pre_fail[4] = is_interrupt_return_instr & f[`TSFC_F_BLFAULT];
  assign pre_fail[5] = is_interrupt_return_instr & f[`TSFC_F_BLNULL];
  assign pre_fail[6] = is_interrupt_return_instr & f[`TSFC_F_BLNOTBUSY];
  assign pre_fail[7] = is_sw & f[`TSFC_F_BEYOND];
  assign pre_fail[8] = is_sw & f[`TSFC_F_NEWNW];
  assign pre_fail[9] = is_sw & f[`TSFC_F_OLDSTORE];
  assign pre_fail[10] = (is_jmp | is_interrupt_return_instr) & f[`TSFC_F_OLDNW];
  assign pre_fail[11] = is_call & f[`TSFC_F_BLNW];
  // An interrupt return resumes a busy task, so the lock checks skip it.
  assign pre_fail[12] = (is_jmp | is_call) & t_null;
  assign pre_fail[13] = (is_jmp | is_call) & t_ti;
  assign pre_fail[14] = (is_jmp | is_call) & f[`TSFC_F_NOTAVAIL];
  assign pre_fail[15] = is_ltr & t_null;
  assign pre_fail[16] = is_ltr & t_ti;
  assign pre_fail[17] = is_ltr & (f[`TSFC_F_BEYOND] |
    (lm & f[`TSFC_F_UPBEYOND]));
  assign pre_fail[18] = is_ltr & f[`TSFC_F_NOTAVAIL];
  assign pre_fail[19] = is_ltr & lm & f[`TSFC_F_IS16];
  assign pre_fail[20] = is_ltr & lm & f[`TSFC_F_UPBADTYPE];
  assign pre_fail[21] = is_ltr & lm & f[`TSFC_F_NONCANON];
  assign pre_fail[22] = is_priv & f[`TSFC_F_STKLIM];
  assign pre_fail[23] = is_priv & lm & f[`TSFC_F_STKCANON];

  tsfc_first #(.N(24), .W(5)) u_pre (
    .fail(pre_fail),
    .any(pre_any),
    .idx()
  );

  // ****************************************************************
  // Post-commit selector checks
  // ****************************************************************
  wire [62:0] segs = {dssel_q, cssel_q, sssel_q};
  wire [3:0] post_fail;
  wire post_any;
  wire [1:0] post_idx;
  assign post_fail[0] = f[`TSFC_F_LDTBAD];
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_seg
      wire [1:0] kind_w = (g == 0) ? `TSFC_KIND_SS :
        (g == 1) ? `TSFC_KIND_CS : `TSFC_KIND_DS;
      tsfc_sel_chk u_chk (
        .kind(kind_w),
        .seg(segs[21*g+20:21*g]),
        .current_privilege_level(current_privilege_level),
        .fail(post_fail[g+1])
      );
    end
  endgenerate

  tsfc_first #(.N(4), .W(2)) u_post (
    .fail(post_fail),
    .any(post_any),
    .idx(post_idx)
  );

  reg [15:0] post_sel;
  reg [3:0] post_chk;
  always @* begin
    case (post_idx)
      2'h0: post_sel = ldtsel_q;
      2'h1: post_sel = sssel_q[15:0];
      2'h2: post_sel = cssel_q[15:0];
      default: post_sel = dssel_q[15:0];
    endcase
    // Checks past the first failure are left undone on purpose.
    case (post_idx)
      2'h0: post_chk = 4'h1;
      2'h1: post_chk = 4'h3;
      2'h2: post_chk = 4'h7;
      default: post_chk = 4'hF;
    endcase
  end

  wire external_event_flag = ctrl_q[`TSFC_CTRL_EXT];
  wire nest = ctrl_q[`TSFC_CTRL_PRIOR_CON] | ctrl_q[`TSFC_CTRL_PRIOR_PF];

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      errcode_q <= 16'h0000;
      taskreg_q <= 16'h0000;
      link_q <= 1'b0;
      loaded_q <= 4'h0;
      checked_q <= 4'h0;
      fault_q <= 1'b0;
      ctx_new_q <= 1'b0;
      ip_new_q <= 1'b0;
      errv_q <= 1'b0;
      commit_q <= 1'b0;
      done_q <= 1'b0;
      fault_pulse <= 1'b0;
      fault_vector <= `TSFC_VEC_NONE;
      double_fault <= 1'b0;
    end else begin
      fault_pulse <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (go) begin
            state_q <= ST_PRE;
            done_q <= 1'b0;
            fault_q <= 1'b0;
            ctx_new_q <= 1'b0;
            ip_new_q <= 1'b0;
            errv_q <= 1'b0;
            commit_q <= 1'b0;
            double_fault <= 1'b0;
            checked_q <= 4'h0;
            loaded_q <= 4'h0;
            fault_vector <= `TSFC_VEC_NONE;
          end
        end
        ST_PRE: begin
          if (pwdata_coproc_q) begin
            // Vector 9 is retired; the overrun goes out as protection.
            fault_q <= 1'b1;
            fault_pulse <= 1'b1;
            fault_vector <= `TSFC_VEC_GP;
            errv_q <= 1'b1;
            errcode_q <= 16'h0000;
            double_fault <= nest;
            state_q <= ST_DONE;
          end else if (pre_any) begin
            // Nothing has been written yet, so the old task owns it.
            fault_q <= 1'b1;
            fault_pulse <= 1'b1;
            fault_vector <= `TSFC_VEC_TS;
            errv_q <= (`TSFC_VEC_TS != `TSFC_VEC_OVERRUN);
            errcode_q <= {tsel[15:2], 1'b0, external_event_flag};
            ctx_new_q <= 1'b0;
            ip_new_q <= 1'b0;
            double_fault <= nest;
            state_q <= ST_DONE;
          end else if (is_sw) begin
            // Commit: task register, link and every segment load in the same cycle.
            taskreg_q <= tsel;
            link_q <= is_call;
            commit_q <= 1'b1;
            loaded_q <= 4'hF;
            state_q <= ST_POST;
          end else begin
            if (is_ltr) begin
              taskreg_q <= tsel;
            end
            state_q <= ST_DONE;
          end
        end
        ST_POST: begin
          if (post_any) begin
            fault_q <= 1'b1;
            fault_pulse <= 1'b1;
            fault_vector <= `TSFC_VEC_TS;
            errv_q <= 1'b1;
            errcode_q <= {post_sel[15:2], 1'b0, external_event_flag};
            ctx_new_q <= 1'b1;
            ip_new_q <= 1'b1;
            double_fault <= nest;
            checked_q <= post_chk;
          end else begin
            checked_q <= 4'hF;
          end
          state_q <= ST_DONE;
        end
        ST_DONE: begin
          done_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // The overrun request is latched with go so a later control write
  // cannot change the outcome of a running operation.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwdata_coproc_q <= 1'b0;
    end else if (go) begin
      pwdata_coproc_q <= pwdata[`TSFC_CTRL_COPROC];
    end
  end
endmodule // tsfc_top
`default_nettype wire

/* File: shared/tsfc_defines.vh */
// Offsets, field positions, vectors and limits of the task state fault checker.
`ifndef TSFC_DEFINES_VH
`define TSFC_DEFINES_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TSFC_OFS_CTRL 8'h00
`define TSFC_OFS_TSSSEL 8'h04
`define TSFC_OFS_TSSFLG 8'h08
`define TSFC_OFS_LDTSEL 8'h0C
`define TSFC_OFS_SSSEL 8'h10
`define TSFC_OFS_CSSEL 8'h14
`define TSFC_OFS_DSSEL 8'h18
`define TSFC_OFS_STATUS 8'h1C
`define TSFC_OFS_ERRCODE 8'h20
`define TSFC_OFS_TASKREG 8'h24
// ****************************************************************
// Control fields
// ****************************************************************
`define TSFC_CTRL_GO 0
`define TSFC_CTRL_OP_LO 1
`define TSFC_CTRL_OP_HI 3
`define TSFC_CTRL_EXT 4
`define TSFC_CTRL_LONG 5
`define TSFC_CTRL_PRIOR_CON 6
`define TSFC_CTRL_PRIOR_PF 7
`define TSFC_CTRL_CPL_LO 8
`define TSFC_CTRL_CPL_HI 9
`define TSFC_CTRL_TSS32 10
`define TSFC_CTRL_COPROC 11
`define TSFC_CTRL_RST 32'h0000_0400
// ****************************************************************
// Operation codes
// ****************************************************************
`define TSFC_OP_INTERRUPT_RETURN_INSTR 3'h0
`define TSFC_OP_JMP 3'h1
`define TSFC_OP_CALL 3'h2
`define TSFC_OP_EXC 3'h3
`define TSFC_OP_LTR 3'h4
`define TSFC_OP_PRIV 3'h5
// ****************************************************************
// Task state descriptor flag positions
// ****************************************************************
`define TSFC_F_SELBEY 0
`define TSFC_F_BUSY 1
`define TSFC_F_BLFAULT 2
`define TSFC_F_BLNULL 3
`define TSFC_F_BLNOTBUSY 4
`define TSFC_F_BEYOND 5
`define TSFC_F_NEWNW 6
`define TSFC_F_OLDSTORE 7
`define TSFC_F_OLDNW 8
`define TSFC_F_BLNW 9
`define TSFC_F_NOTAVAIL 10
`define TSFC_F_UPBEYOND 11
`define TSFC_F_UPBADTYPE 12
`define TSFC_F_NONCANON 13
`define TSFC_F_IS16 14
`define TSFC_F_STKLIM 15
`define TSFC_F_STKCANON 16
`define TSFC_F_LDTBAD 17
// ****************************************************************
// Segment selector register fields
// ****************************************************************
`define TSFC_S_DPL_LO 16
`define TSFC_S_DPL_HI 17
`define TSFC_S_BEYOND 18
`define TSFC_S_F1 19
`define TSFC_S_F2 20
`define TSFC_KIND_SS 2'h0
`define TSFC_KIND_CS 2'h1
`define TSFC_KIND_DS 2'h2
// ****************************************************************
// Vectors and limits
// ****************************************************************
`define TSFC_VEC_NONE 8'h00
`define TSFC_VEC_OVERRUN 8'h09
`define TSFC_VEC_TS 8'h0A
`define TSFC_VEC_GP 8'h0D
`define TSFC_LIM32 16'h0067
`define TSFC_LIM16 16'h002C
`endif

/* File: rtl/tsfc_first.v */
// First-set picker over an ordered vector of check failures.
`timescale 1ns/1ps
`default_nettype none
module tsfc_first #(
  parameter N = 24,
  parameter W = 5
) (
  input wire [N-1:0] fail,
  output reg any,
  output reg [W-1:0] idx
);
  integer i;
  always @* begin
    any = 1'b0;
    idx = {W{1'b0}};
    // Scan from the top down so the lowest index, checked first, wins.
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (fail[i]) begin
        any = 1'b1;
        idx = i[W-1:0];
      end
    end
  end
endmodule // tsfc_first
`default_nettype wire

/* File: rtl/tsfc_sel_chk.v */
// Validity check of one stack, code or data selector loaded from a task.
`timescale 1ns/1ps
`default_nettype none
`include "tsfc_defines.vh"
module tsfc_sel_chk (
  input wire [1:0] kind,
  input wire [20:0] seg,
  input wire [1:0] current_privilege_level,
  output reg fail
);
  wire [1:0] descriptor_privilege_level = seg[`TSFC_S_DPL_HI:`TSFC_S_DPL_LO];
  wire [1:0] requested_privilege_level = seg[1:0];
  wire null_sel = (seg[15:2] == 14'h0000);
  wire beyond = seg[`TSFC_S_BEYOND];
  wire f1 = seg[`TSFC_S_F1];
  wire f2 = seg[`TSFC_S_F2];
  always @* begin
    case (kind)
      `TSFC_KIND_SS: fail = beyond | null_sel | ~f1 | ~f2 |
        (descriptor_privilege_level != current_privilege_level) | (requested_privilege_level != current_privilege_level);
      `TSFC_KIND_CS: fail = beyond | null_sel | ~f1 |
        (~f2 & (descriptor_privilege_level != current_privilege_level)) | (f2 & (descriptor_privilege_level > current_privilege_level));
      `TSFC_KIND_DS: fail = beyond | ~f1 |
        (f2 & ((requested_privilege_level > descriptor_privilege_level) | (current_privilege_level > descriptor_privilege_level)));
      default: fail = 1'b0;
    endcase
  end
endmodule // tsfc_sel_chk
`default_nettype wire

/* File: testbench/tsfc_monitor.sv */
// Port-level assertions for the task state fault checker.
`timescale 1ns/1ps
`default_nettype none
module tsfc_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fault_pulse,
  input wire logic [7:0] fault_vector,
  input wire logic double_fault
);
  // ********
  // Helper logic
  // ********
  logic acc, go;
  logic [2:0] since_q;
  logic prior_q;
  assign acc = psel && penable;
  assign go = acc && pwrite && paddr == 8'h00 && pwdata[0];
  // The count saturates so an idle block never wraps back into a run.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_q <= 3'h7;
      prior_q <= 1'b0;
    end else if (go) begin
      since_q <= 3'h0;
      prior_q <= pwdata[6] | pwdata[7];
    end else if (since_q != 3'h7) begin
      since_q <= since_q + 3'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ********
  // Assertions
  // ********
  chk_vec_legal: assert property (
    fault_pulse |-> fault_vector inside {8'h0A, 8'h0D})
    else $error("fault raised with an illegal vector");
  chk_pulse_single: assert property (
    fault_pulse |=> !fault_pulse)
    else $error("fault pulse longer than one cycle");
  chk_pulse_timing: assert property (
    fault_pulse |-> since_q inside {[3'h1:3'h4]})
    else $error("fault pulse outside the run window");
  chk_coproc_gp: assert property (
    go && pwdata[11] |-> ##[1:4] fault_pulse && fault_vector == 8'h0D)
    else $error("coprocessor event not reported as protection fault");
  chk_double_match: assert property (
    fault_pulse |-> double_fault == prior_q)
    else $error("double fault flag disagrees with prior class");
  chk_vec_cause: assert property (
    $changed(fault_vector) && fault_vector != 8'h00 |-> fault_pulse)
    else $error("vector changed without a fault pulse");
  chk_vec_hold: assert property (
    since_q > 3'h4 |-> $stable(fault_vector) && $stable(double_fault))
    else $error("fault outputs moved while idle");
  chk_unmapped_err: assert property (
    acc && paddr > 8'h24 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (
    acc && paddr <= 8'h24 && paddr[1:0] == 2'h0 |-> pready && !pslverr)
    else $error("mapped access refused or stalled");
  cover property (fault_pulse && fault_vector == 8'h0A);
  cover property (fault_pulse && double_fault);
  cover property (acc && pslverr);
endmodule // tsfc_monitor

bind tsfc_top tsfc_monitor mon_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fault_pulse(fault_pulse), .fault_vector(fault_vector),
  .double_fault(double_fault));
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the task state fault checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, fault_pulse, double_fault;
  logic [7:0] fault_vector;
  logic [31:0] rd_v[$], rd_m[$];
  logic [8:0] flt_q[$];
  logic [31:0] tr, ok_ss, ok_cs, ok_ds, c, x, y;
  logic [15:0] lfsr, sel, s;
  logic [2:0] op;
  logic [1:0] k;
  int mismatches, checks_done, i;
  logic [31:0] px[15] = '{32'h0004_0000, 32'h0000_FFFF, 32'h0008_0000,
    32'h0010_0000, 32'h0001_0000, 32'h0000_0001, 32'h4004_0000,
    32'h4000_FFFF, 32'h4008_0000, 32'h4001_0000, 32'h4011_0000,
    32'h8004_0000, 32'h8008_0000, 32'h8010_0001, 32'hC000_0000};

  tsfc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_pulse(fault_pulse), .fault_vector(fault_vector),
    .double_fault(double_fault));

  // ********
  // Helpers
  // ********
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] ctl(input logic [2:0] o, input logic e,
      input logic l);
    return {21'h0, 1'b1, 4'h0, l, e, o, 1'b0};
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bad(input logic [31:0] g, input logic [31:0] e);
    mismatches++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
  endtask
  // Reads queue their expectation first; a zero mask marks a status poll.
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] m, output logic [31:0] r);
    int n;
    @(posedge pclk);
    if (!w) begin
      rd_v.push_back(d);
      rd_m.push_back(m);
    end
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      bad(32'h0, 32'h1);
      print_verdict();
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
    logic [31:0] r;
    apb(1'b0, a, e, m, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, 32'h0, r);
  endtask
  task automatic prep;
    lfsr = nxt(lfsr);
    sel = {lfsr[12:0] | 13'h100, 3'h0};
    ok_ss = {16'h0018, sel ^ 16'h0010};
    ok_cs = {16'h0008, sel ^ 16'h0018};
    ok_ds = {16'h0008, sel ^ 16'h0020};
  endtask
  task automatic cfg(input logic [31:0] t, input logic [31:0] f,
      input logic [31:0] a, input logic [31:0] b, input logic [31:0] d);
    wr(8'h04, t);
    wr(8'h08, f);
    wr(8'h0C, {16'h0, sel ^ 16'h0008});
    wr(8'h10, a);
    wr(8'h14, b);
    wr(8'h18, d);
  endtask
  task automatic run(input logic [31:0] cw, input logic [8:0] f,
      input logic [15:0] es, input logic [31:0] st, input logic [31:0] sm);
    logic [31:0] r;
    int n;
    if (f != 9'h0)
      flt_q.push_back(f);
    wr(8'h00, cw | 32'h1);
    n = 0;
    do begin
      apb(1'b0, 8'h1C, 32'h0, 32'h0, r);
      n++;
    end while (r[1] !== 1'b1 && n < 16);
    if (n >= 16) begin
      bad(r, 32'h2);
      print_verdict();
    end
    rd(8'h1C, st, sm);
    if (f != 9'h0)
      rd(8'h20, {16'h0, es[15:2], 1'b0, cw[4]}, 32'hFFFF_FFFF);
    rd(8'h24, tr, 32'hFFFF_FFFF);
  endtask

  // ********
  // Result watcher
  // ********
  always @(posedge pclk) begin : watch
    logic [31:0] v, m;
    logic [8:0] f;
    if (psel && penable && pready && !pwrite && rd_v.size() > 0) begin
      v = rd_v.pop_front();
      m = rd_m.pop_front();
      if (m != 32'h0) begin
        checks_done++;
        if ((prdata & m) !== v) bad(prdata & m, v);
      end
    end
    if (fault_pulse === 1'b1) begin
      f = flt_q.size() > 0 ? flt_q.pop_front() : 9'h0;
      checks_done++;
      if ({double_fault, fault_vector} !== f)
        bad({23'h0, double_fault, fault_vector}, {23'h0, f});
    end
  end

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ********
  // Main sequence
  // ********
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tr = 32'h0;
    lfsr = 16'h4414;
    mismatches = 0;
    checks_done = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i <= 10; i++)
      rd(8'(i * 4), i == 0 ? 32'h400 : 32'h0, 32'hFFFF_FFFF);
    $display("reset values done");
    for (i = 0; i < 17; i++) begin
      prep();
      op = i < 5 ? 3'h0 : i < 9 ? 3'h1 : i < 10 ? 3'h2 : i < 11 ? 3'h3 :
        i < 15 ? 3'h4 : 3'h5;
      y = (op == 3'h0 ? 32'h2 : 32'h0) ^ (32'h1 << i);
      cfg({16'h0067, sel}, y, ok_ss, ok_cs, ok_ds);
      c = ctl(op, lfsr[0], i > 10);
      run(c, 9'h00A, sel, 32'h0A46, 32'hFF_FFFF);
    end
    $display("descriptor checks done");
    for (i = 0; i < 6; i++) begin
      prep();
      c = ctl(i < 4 ? 3'h1 : 3'h4, 1'b1, 1'b0);
      c[10] = i != 1;
      s = i == 2 || i == 4 ? 16'h0 : i > 2 ? sel | 16'h4 : sel;
      y = {i == 0 ? 16'h0066 : i == 1 ? 16'h002B : 16'h0067, s};
      cfg(y, 32'h0, ok_ss, ok_cs, ok_ds);
      run(c, 9'h00A, s, 32'h0A46, 32'hFF_FFFF);
    end
    $display("selector checks done");
    for (i = 0; i < 15; i++) begin
      prep();
      x = px[i];
      k = x[31:30];
      y = {2'h0, x[29:0]};
      op = 3'(i % 4);
      s = k == 2'h0 ? ok_ss[15:0] : k == 2'h1 ? ok_cs[15:0] :
        k == 2'h2 ? ok_ds[15:0] : sel ^ 16'h0008;
      if (y[15:0] == 16'hFFFF)
        y[15:0] = s;
      s = s ^ y[15:0];
      tr = {15'h0, op == 3'h2 || op == 3'h3, sel};
      cfg({16'h0067, sel}, (op == 3'h0 ? 32'h2 : 32'h0) |
        (k == 2'h3 ? 32'h2_0000 : 32'h0),
        ok_ss ^ (k == 2'h0 ? y : k == 2'h3 ? 32'h8_0000 : 32'h0),
        ok_cs ^ (k == 2'h1 ? y : k == 2'h0 ? 32'h8_0000 : 32'h0),
        ok_ds ^ (k == 2'h2 ? y : k == 2'h1 ? 32'h8_0000 : 32'h0));
      c = ctl(op, lfsr[1], 1'b0);
      run(c, 9'h00A, s, 32'hF_0ADE, 32'hF_FFFF);
    end
    $display("post commit checks done");
    for (i = 0; i < 4; i++) begin
      prep();
      c = ctl(i == 3 ? 3'h4 : 3'(i + 1), 1'b0, 1'b0);
      c[10] = i != 1;
      c[6] = i == 2;
      y = {i == 1 ? 16'h002C : 16'h0067, sel};
      cfg(y, i == 3 ? 32'h4000 : 32'h0, ok_ss, ok_cs, ok_ds);
      tr = {15'h0, i != 0, sel};
      run(c, 9'h0, 16'h0, i == 3 ? 32'h02 : 32'hFF_0082,
        i == 3 ? 32'hFF : 32'hFF_FFE7);
    end
    $display("clean switch checks done");
    for (i = 0; i < 3; i++) begin
      prep();
      c = ctl(3'h1, 1'b0, 1'b0) | (i == 2 ? 32'h800 : 32'h40 << i);
      y = {i == 2 ? 16'h0067 : 16'h0066, sel};
      cfg(y, 32'h0, ok_ss, ok_cs, ok_ds);
      run(c, i == 2 ? 9'h00D : 9'h10A, i == 2 ? 16'h0 : sel,
        i == 2 ? 32'h0D46 : 32'h0A66, 32'hFFFF);
    end
    $display("double fault and coprocessor checks done");
    repeat (4) @(posedge pclk);
    checks_done++;
    if (flt_q.size() != 0)
      bad(flt_q.size(), 32'h0);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
